// File: common/dhi_map.svh
// Timing constants for the two-hand initiation monitor.
`ifndef DHI_MAP_SVH
`define DHI_MAP_SVH
`define DHI_CLK_HZ 25000000
`define DHI_WINDOW_MS 500
`define DHI_WINDOW_CYC ((`DHI_CLK_HZ / 1000) * `DHI_WINDOW_MS)
`define DHI_CNT_W 24
`endif

// File: common/dhi_pkg.sv
// Types for the two-hand initiation monitor.
package dhi_pkg;
	typedef enum logic [1:0]
	{
		DHI_IDLE  = 2'b00,
		DHI_TIMED = 2'b01,
		DHI_RUN   = 2'b10,
		DHI_LOCK  = 2'b11
	} dhi_state_type;
endpackage

// File: src/dhi_monitor.sv
// Two-hand initiation monitor driving the run permit.
`include "dhi_map.svh"
module dhi_monitor
#(
	parameter int unsigned WINDOW_CYC = `DHI_WINDOW_CYC
)
(
	input  wire logic core_clk,
	input  wire logic arst_n,
	input  wire logic hand_a,
	input  wire logic hand_b,
	output logic      run_permit,
	output logic      window_fault
);
	logic                  meta_a_r;
	logic                  meta_b_r;
	logic                  sync_a_r;
	logic                  sync_b_r;
	dhi_pkg::dhi_state_type state_r;
	dhi_pkg::dhi_state_type state_nxt;
	logic [`DHI_CNT_W-1:0] cnt_r;
	logic [`DHI_CNT_W-1:0] cnt_nxt;
	logic                  permit_r;
	logic                  permit_nxt;
	logic                  fault_r;
	logic                  fault_nxt;
	logic                  both;
	logic                  none;
	logic                  meta_a_nxt;
	logic                  meta_b_nxt;
	logic                  sync_a_nxt;
	logic                  sync_b_nxt;

	// Window length cut to the counter width; the default of 500 ms fits in 24 bits.
	function automatic logic [`DHI_CNT_W-1:0] limit_cyc();
		return `DHI_CNT_W'(WINDOW_CYC);
	endfunction

	// True while a count still lies inside the simultaneity window.
	function automatic logic in_window
	(
		input logic [`DHI_CNT_W-1:0] count
	);
		return count <= limit_cyc();
	endfunction

	// True once a count has used up the whole simultaneity window.
	function automatic logic window_spent
	(
		input logic [`DHI_CNT_W-1:0] count
	);
		return count >= limit_cyc();
	endfunction

	// One step of the window counter, kept at the counter width.
	function automatic logic [`DHI_CNT_W-1:0] next_count
	(
		input logic [`DHI_CNT_W-1:0] count
	);
		return count + `DHI_CNT_W'(1);
	endfunction

	// True when both hand controls are actuated.
	function automatic logic pair_all
	(
		input logic a,
		input logic b
	);
		return a && b;
	endfunction

	// True when both hand controls are released.
	function automatic logic pair_none
	(
		input logic a,
		input logic b
	);
		return !a && !b;
	endfunction

	// Next values of the synchroniser chain; only the second stage feeds the state machine.
	always_comb
	begin
		meta_a_nxt = hand_a;
		meta_b_nxt = hand_b;
		sync_a_nxt = meta_a_r;
		sync_b_nxt = meta_b_r;
	end

	// Two-stage synchronisers on both hand controls.
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			meta_a_r <= 1'b0;
			meta_b_r <= 1'b0;
			sync_a_r <= 1'b0;
			sync_b_r <= 1'b0;
		end
		else
		begin
			meta_a_r <= meta_a_nxt;
			meta_b_r <= meta_b_nxt;
			sync_a_r <= sync_a_nxt;
			sync_b_r <= sync_b_nxt;
		end
	end

	assign both = pair_all(sync_a_r, sync_b_r);
	assign none = pair_none(sync_a_r, sync_b_r);

	// Window state machine; the counter only runs while one hand waits for the other.
	always_comb
	begin
		state_nxt  = state_r;
		cnt_nxt    = cnt_r;
		permit_nxt = 1'b0;
		fault_nxt  = fault_r;
		unique case (state_r)
			dhi_pkg::DHI_IDLE:
			begin
				cnt_nxt = '0;
				if (both)
				begin
					state_nxt  = dhi_pkg::DHI_RUN;
					permit_nxt = 1'b1;
				end
				else if (!none)
				begin
					state_nxt = dhi_pkg::DHI_TIMED;
					cnt_nxt   = `DHI_CNT_W'(1);
				end
			end
			dhi_pkg::DHI_TIMED:
			begin
				if (none)
				begin
					state_nxt = dhi_pkg::DHI_IDLE;
				end
				else if (both && in_window(cnt_r))
				begin
					state_nxt  = dhi_pkg::DHI_RUN;
					permit_nxt = 1'b1;
				end
				else if (window_spent(cnt_r))
				begin
					state_nxt = dhi_pkg::DHI_LOCK;
					fault_nxt = 1'b1;
				end
				else
				begin
					cnt_nxt = next_count(cnt_r);
				end
			end
			dhi_pkg::DHI_RUN:
			begin
				if (both)
				begin
					permit_nxt = 1'b1;
				end
				else
				begin
					state_nxt = dhi_pkg::DHI_LOCK;
				end
			end
			dhi_pkg::DHI_LOCK:
			begin
				if (none)
				begin
					state_nxt = dhi_pkg::DHI_IDLE;
					fault_nxt = 1'b0;
				end
			end
		endcase
	end

	// State and window counter registers.
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_r <= dhi_pkg::DHI_IDLE;
			cnt_r   <= '0;
		end
		else
		begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
		end
	end

	// The permit flop drives the pin directly, so no gate can glitch it high.
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			permit_r <= 1'b0;
		end
		else
		begin
			permit_r <= permit_nxt;
		end
	end

	// The fault flop holds the window expiry until both hands are seen released.
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			fault_r <= 1'b0;
		end
		else
		begin
			fault_r <= fault_nxt;
		end
	end

	// Both outputs come straight from their flops.
	assign run_permit   = permit_r;
	assign window_fault = fault_r;
endmodule

// File: tb/dhi_hands.sv
// Model of the two hand controls.
module dhi_hands
(
	input  wire logic       core_clk,
	input  wire logic [1:0] press,
	output logic            hand_a = 1'h0,
	output logic            hand_b = 1'h0
);
	timeunit 1ns;
	timeprecision 1ns;
	always @(posedge core_clk) #1 {hand_a, hand_b} <= press;
endmodule

// File: tb/dhi_asserts.sv
// Checker of the run permit.
module dhi_asserts
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic hand_a,
	input wire logic hand_b,
	input wire logic run_permit,
	input wire logic window_fault
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	a_drop_fast: assert property (!(hand_a && hand_b) |-> ##3 !run_permit)
		else $error("slow");
	a_both_held: assert property (run_permit |-> $past(hand_a, 3) && $past(hand_b, 3))
		else $error("held");
	a_fault_block: assert property (window_fault |-> !run_permit)
		else $error("fault");
	a_one_hand: assert property ($rose(window_fault) |-> $past(hand_a ^ hand_b, 3))
		else $error("one");
	a_rearm_gap: assert property ($fell(run_permit) |-> !run_permit [*2])
		else $error("rearm");
	a_sync_lag: assert property ($rose(hand_a && hand_b) && !run_permit |=> !run_permit [*2])
		else $error("lag");
endmodule
bind dhi_monitor dhi_asserts dhi_asserts_i
(
	.core_clk     (core_clk),
	.arst_n       (arst_n),
	.hand_a       (hand_a),
	.hand_b       (hand_b),
	.run_permit   (run_permit),
	.window_fault (window_fault)
);

// File: tb/dhi_monitor_test.sv
// Bench of the monitor.
module dhi_monitor_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 0, arst_n = 0, run_permit, window_fault, hand_a, hand_b;
	logic [1:0] press = 2'h0;
	int num_errors = 0, num_checks = 0, cyc = 0, num_strokes = 0;
	dhi_hands dhi_hands_i
	(
		.core_clk (core_clk),
		.press    (press),
		.hand_a   (hand_a),
		.hand_b   (hand_b)
	);
	dhi_monitor #(.WINDOW_CYC(20)) dhi_monitor_i
	(
		.core_clk     (core_clk),
		.arst_n       (arst_n),
		.hand_a       (hand_a),
		.hand_b       (hand_b),
		.run_permit   (run_permit),
		.window_fault (window_fault)
	);
	always @(posedge run_permit) num_strokes++;
	task automatic check_strokes(int e);
		num_checks++;
		if (num_strokes != e)
		begin
			num_errors++;
			$display("BAD %0t %h %h", $time, num_strokes, e);
		end
	endtask
	initial forever #20 core_clk = ~core_clk;
	always @(posedge core_clk) if (++cyc > 300)
	begin
		num_errors++;
		complete_run;
	end
	task automatic go(logic [1:0] p, int n, logic [1:0] e);
		press = p;
		repeat (n) @(posedge core_clk);
		#2 num_checks++;
		if ({run_permit, window_fault} !== e)
		begin
			num_errors++;
			$display("BAD %0t %h %h", $time, {run_permit, window_fault}, e);
		end
	endtask
	task automatic t_grant;
		go(2'h2, 6, 2'h0);
		go(2'h3, 5, 2'h2);
		go(2'h1, 5, 2'h0);
		go(2'h3, 6, 2'h0);
		go(2'h0, 5, 2'h0);
		go(2'h3, 5, 2'h2);
		go(2'h0, 5, 2'h0);
		check_strokes(2);
	endtask
	task automatic t_late;
		go(2'h1, 30, 2'h1);
		go(2'h3, 6, 2'h1);
		go(2'h0, 6, 2'h0);
		check_strokes(2);
	endtask
	task automatic complete_run;
		if (num_errors == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (2) @(posedge core_clk);
		#2 arst_n = 1;
		t_grant;
		t_late;
		complete_run;
	end
endmodule
